// ===== tb_tfc_framer_ctl.sv
// Self-checking testbench for the T1 framer control block
`timescale 1ns/1ps
`default_nettype none
module tb_tfc_framer_ctl;
	logic        core_clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, irq_out_n, inframe_state, mimic_present, jpn_esf_mode;
	logic        fbit_strobe, fbit_value, fbit_error, fbit_is_ft, sync_error, sf_start;
	logic        line_bit, line_bit_valid, line_bit_is_fbit, crc_check, cand_lock;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [5:0]  crc_rx;
	logic [7:0]  cand_pos;
	logic [2:0]  cand_count;
	int          n_mismatch = 0, compares = 0, cyc = 0;
	// Address, write value, read-back value; ratio 11 and test bit never written
	logic [27:0] rows [5] = '{{12'h120, 8'h01, 8'h00}, {12'h120, 8'h4c, 8'h4c},
		{12'h124, 8'h3f, 8'h3f}, {12'h124, 8'h00, 8'h00}, {12'h120, 8'hb2, 8'hb2}};
	tfc_framer_ctl tfc_framer_ctl_i (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.fbit_strobe, .fbit_value, .fbit_error, .fbit_is_ft, .sync_error, .sf_start,
		.line_bit, .line_bit_valid, .line_bit_is_fbit, .crc_check, .crc_rx, .cand_lock,
		.cand_pos, .cand_count, .irq_out_n, .inframe_state, .mimic_present, .fdl_bit(),
		.fdl_valid(), .far_end_alarm(), .jpn_esf_mode);
	tfc_line_model tfc_line_model_i (.core_clk, .fbit_strobe, .fbit_value, .fbit_error,
		.fbit_is_ft, .sync_error, .sf_start, .line_bit, .line_bit_valid, .line_bit_is_fbit,
		.crc_check, .crc_rx, .cand_lock, .cand_pos, .cand_count);
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_mismatch++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bit aw_ok = 1'b0;
		bit w_ok = 1'b0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge core_clk);
			aw_ok |= s_axi_awready;
			w_ok |= s_axi_wready;
			s_axi_awvalid <= !aw_ok;
			s_axi_wvalid <= !w_ok;
		end
		while (!(aw_ok && w_ok));
		do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [7:0] e, input bit cmp = 1'b1);
		@(posedge core_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (cmp)
			chk(rd, {24'h0, e});
	endtask
	task automatic end_sim();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		{reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h1;
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		rc(12'h120, 8'h00);
		rc(12'h124, 8'h00);
		rc(12'h128, 8'h00);
		rc(12'h12c, 8'h00);
		chk({30'h0, rsp}, {30'h0, tfc_pkg::RESP_SLVERR});
		foreach (rows[i])
		begin
			wr(rows[i][27:16], rows[i][15:8]);
			rc(rows[i][27:16], rows[i][7:0]);
		end
		chk({31'h0, jpn_esf_mode}, 32'h1);
		$display("test registers done");
		wr(12'h120, 8'h00);
		wr(12'h124, 8'h10);
		tfc_line_model_i.fbit(1'b1, 1'b1);
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq_out_n}, 32'h0);
		rc(12'h128, 8'h60);
		rc(12'h128, 8'h00);
		chk({31'h0, irq_out_n}, 32'h1);
		wr(12'h124, 8'h00);
		tfc_line_model_i.fbit(1'b1, 1'b1);
		tfc_line_model_i.fbit(1'b1, 1'b0);
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq_out_n}, 32'h1);
		rc(12'h128, 8'h70);
		$display("test errors done");
		wr(12'h124, 8'h02);
		tfc_line_model_i.cnt(3'h2);
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq_out_n}, 32'h0);
		rc(12'h128, 8'h0a);
		tfc_line_model_i.cnt(3'h1);
		repeat (3) @(posedge core_clk);
		rc(12'h128, 8'h08);
		wr(12'h120, 8'h10);
		tfc_line_model_i.lock(8'h03, 3'h2);
		tfc_line_model_i.cnt(3'h1);
		repeat (3) @(posedge core_clk);
		chk({31'h0, inframe_state}, 32'h0);
		rc(12'h128, 8'h08);
		$display("test mimic done");
		wr(12'h124, 8'h01);
		tfc_line_model_i.lock(8'h05, 3'h1);
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq_out_n}, 32'h0);
		rc(12'h128, 8'h00, 1'b0);
		chk(rd & 32'h7f, 32'h05);
		wr(12'h120, 8'h40);
		for (int i = 0; i < 5; i++)
			tfc_line_model_i.fbit(i == 0 || i == 4, i == 2);
		repeat (3) @(posedge core_clk);
		chk({31'h0, inframe_state}, 32'h0);
		rc(12'h128, 8'h00, 1'b0);
		tfc_line_model_i.lock(8'h09, 3'h1);
		repeat (3) @(posedge core_clk);
		rc(12'h128, 8'h85);
		$display("test alignment done");
		wr(12'h100, 8'h01);
		rc(12'h120, 8'h00);
		rc(12'h124, 8'h00);
		rc(12'h128, 8'h00);
		$display("test held reset done");
		end_sim();
	end
endmodule // tb_tfc_framer_ctl
`default_nettype wire

// ===== tfc_evt_flags.sv
// Sticky event flags, cleared by a status read or by the held-reset condition
`timescale 1ns/1ps
`default_nettype none
module tfc_evt_flags #(
	parameter int N = 6
) (
	input  wire logic         core_clk,
	input  wire logic         reset,
	input  wire logic         hold,
	input  wire logic [N-1:0] set,
	input  wire logic         clr,
	output var  logic [N-1:0] flags
);
	logic [N-1:0] next_flags;

	// ---------------------------------------------------------------
	// Set wins over a clear in the same cycle
	// ---------------------------------------------------------------
	always_comb
	begin
		if (hold)
			next_flags = '0;
		else if (clr)
			next_flags = set; // [RL22]
		else
			next_flags = flags | set; // [RL19]
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			flags <= '0;
		else
			flags <= next_flags;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	a_flag_set_wins: assert property (!hold && set[0] |=> flags[0]) // [RL19]
		else $error("event lost on flag 0");
	a_read_clears: assert property (clr && !hold && set == '0 |=> flags == '0) // [RL22]
		else $error("status read did not clear flags");
endmodule // tfc_evt_flags
`default_nettype wire

// ===== tfc_framer_ctl.sv
// T1 framer configuration, framing state, events and register slave
// How it works
// RL1 - E1 or unframed holds registers in reset
// RL2 - OOF at 2 of 4/5/6 per ratio
// RL3 - Data-multiplex OOF at 4 of 12 always
// RL4 - Software never writes ratio value 11
// RL5 - Algorithm 0: no lock while mimics exist
// RL6 - Algorithm 1: CRC-6 picks the candidate
// RL7 - Mode field picks SF, DM or loop-carrier
// RL8 - ESF: data link from every odd frame
// RL9 - Software keeps mode 00 under ESF
// RL10 - Japanese bit under ESF selects national variant
// RL11 - Japanese non-ESF: alarm from 12th F-bit
// RL12 - Software keeps production-test enable at 0
// RL13 - New alignment position raises alignment-change event
// RL14 - Any framing bit error raises framing event; code skips 12th F-bit errors in Japanese non-ESF with alarm set
// RL15 - Bit-error event source depends on format
// RL16 - Two errors in superframe: severe event
// RL17 - Mimic flagged; both edges are events
// RL18 - In-frame edges interrupt only when enabled
// RL19 - Event status bits set on their event
// RL20 - Mimic status set on either mimic edge
// RL21 - Live mimic and in-frame bits readable
// RL22 - Status read clears all six event bits
// RL23 - In-frame status set on in-frame change
// RL24 - Interrupt low while enabled status bit set
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tfc_framer_ctl #(
	parameter int POS_W = 8
) (
	input  wire logic                        core_clk,
	input  wire logic                        reset,
	input  wire logic [tfc_pkg::AXI_AW-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output var  logic                        s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output var  logic                        s_axi_wready,
	output var  logic [1:0]                  s_axi_bresp,
	output var  logic                        s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [tfc_pkg::AXI_AW-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output var  logic                        s_axi_arready,
	output var  logic [31:0]                 s_axi_rdata,
	output var  logic [1:0]                  s_axi_rresp,
	output var  logic                        s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic                        fbit_strobe,
	input  wire logic                        fbit_value,
	input  wire logic                        fbit_error,
	input  wire logic                        fbit_is_ft,
	input  wire logic                        sync_error,
	input  wire logic                        sf_start,
	input  wire logic                        line_bit,
	input  wire logic                        line_bit_valid,
	input  wire logic                        line_bit_is_fbit,
	input  wire logic                        crc_check,
	input  wire logic [5:0]                  crc_rx,
	input  wire logic                        cand_lock,
	input  wire logic [POS_W-1:0]            cand_pos,
	input  wire logic [2:0]                  cand_count,
	output var  logic                        irq_out_n,
	output var  logic                        inframe_state,
	output var  logic                        mimic_present,
	output var  logic                        fdl_bit,
	output var  logic                        fdl_valid,
	output var  logic                        far_end_alarm,
	output var  logic                        jpn_esf_mode
);
	logic [7:0]             gctl, cfg, ien;
	logic [7:0]             next_gctl, next_cfg, next_ien;
	logic                   aw_have, w_have, next_aw_have, next_w_have, wr_en, next_wr_en;
	logic [7:0]             wr_idx, next_wr_idx;
	logic [7:0]             wr_data, next_wr_data;
	logic                   next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]             next_bresp, next_rresp;
	logic [31:0]            next_rdata;
	logic                   do_wr, ar_take, hold, clr_ist;
	logic [7:0]             rd_idx;
	tfc_pkg::tfc_fmt_e      fmt;
	tfc_pkg::tfc_frm_e      frm, next_frm;
	logic [POS_W-1:0]       pos, next_pos;
	logic                   had_align, next_had_align;
	logic [4:0]             fnum, next_fnum, fnum_cur;
	logic [1:0]             sf_errs, next_sf_errs;
	logic [5:0]             crc, next_crc;
	logic                   crc_ok, next_crc_ok, crc_bad, next_crc_bad, crc_fb;
	logic                   next_fdl_bit, next_fdl_valid, next_alarm, next_mimic;
	logic                   fer_in, sev_in, bee_in, lock_ok, oof, next_irq_n;
	logic [3:0]             win_len;
	logic [2:0]             thresh;
	logic [5:0]             evt, flags;

	function automatic tfc_pkg::tfc_fmt_e fmt_decode(input logic [7:0] c);
		if (c[tfc_pkg::CFG_ESF])
			return tfc_pkg::TFC_ESF;
		else if (c[tfc_pkg::CFG_FMS +: 2] == tfc_pkg::FMS_SF)
			return tfc_pkg::TFC_SF;
		else if (c[tfc_pkg::CFG_FMS +: 2] == tfc_pkg::FMS_SLC)
			return tfc_pkg::TFC_SLC;
		else
			return tfc_pkg::TFC_DM;
	endfunction

	function automatic logic [7:0] addr_idx(input logic [tfc_pkg::AXI_AW-1:0] a);
		return a[9:2];
	endfunction

	function automatic logic idx_known(input logic [7:0] i);
		return i == tfc_pkg::IDX_GCTL || i == tfc_pkg::IDX_CFG
			|| i == tfc_pkg::IDX_IEN || i == tfc_pkg::IDX_IST;
	endfunction

	// ---------------------------------------------------------------
	// Register slave
	// ---------------------------------------------------------------
	assign hold    = gctl[tfc_pkg::GCTL_E1] | gctl[tfc_pkg::GCTL_UNF];
	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign rd_idx  = addr_idx(s_axi_araddr);
	assign clr_ist = ar_take && rd_idx == tfc_pkg::IDX_IST; // [RL22]
	assign do_wr   = aw_have & w_have & ~s_axi_bvalid;

	always_comb
	begin
		next_aw_have = aw_have | (s_axi_awvalid & s_axi_awready);
		next_w_have  = w_have | (s_axi_wvalid & s_axi_wready);
		next_wr_idx  = (s_axi_awvalid & s_axi_awready) ? addr_idx(s_axi_awaddr) : wr_idx;
		next_wr_data = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata[7:0] : wr_data;
		next_wr_en   = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb[0] : wr_en;
		next_bvalid  = s_axi_bvalid & ~s_axi_bready;
		next_bresp   = s_axi_bresp;
		next_gctl    = gctl;
		next_cfg     = cfg;
		next_ien     = ien;
		if (do_wr)
		begin
			next_aw_have = 1'b0;
			next_w_have  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = idx_known(wr_idx) ? tfc_pkg::RESP_OKAY : tfc_pkg::RESP_SLVERR;
			if (wr_en)
			begin
				if (wr_idx == tfc_pkg::IDX_GCTL)
					next_gctl = wr_data;
				if (wr_idx == tfc_pkg::IDX_CFG)
					next_cfg = wr_data & tfc_pkg::CFG_MASK; // [RL4] [RL9]
				if (wr_idx == tfc_pkg::IDX_IEN)
					next_ien = wr_data & tfc_pkg::IEN_MASK; // [RL12]
			end
		end
		if (hold)
		begin
			next_cfg = tfc_pkg::REG_RST; // [RL1]
			next_ien = tfc_pkg::REG_RST; // [RL1]
		end
		next_awready = ~next_aw_have & ~next_bvalid;
		next_wready  = ~next_w_have & ~next_bvalid;
		next_rvalid  = ar_take | (s_axi_rvalid & ~s_axi_rready);
		next_arready = ~next_rvalid & ~ar_take;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		if (ar_take)
		begin
			next_rdata = 32'h0;
			next_rresp = idx_known(rd_idx) ? tfc_pkg::RESP_OKAY : tfc_pkg::RESP_SLVERR;
			case (rd_idx)
				tfc_pkg::IDX_GCTL: next_rdata[7:0] = gctl;
				tfc_pkg::IDX_CFG:  next_rdata[7:0] = cfg;
				tfc_pkg::IDX_IEN:  next_rdata[7:0] = ien;
				tfc_pkg::IDX_IST:  next_rdata[7:0] = {flags, mimic_present, inframe_state}; // [RL21]
				default:           next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			wr_idx        <= 8'h00;
			wr_data       <= 8'h00;
			wr_en         <= 1'b0;
			gctl          <= tfc_pkg::REG_RST;
			cfg           <= tfc_pkg::REG_RST;
			ien           <= tfc_pkg::REG_RST;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= tfc_pkg::RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= tfc_pkg::RESP_OKAY;
		end
		else
		begin
			aw_have       <= next_aw_have;
			w_have        <= next_w_have;
			wr_idx        <= next_wr_idx;
			wr_data       <= next_wr_data;
			wr_en         <= next_wr_en;
			gctl          <= next_gctl;
			cfg           <= next_cfg;
			ien           <= next_ien;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	// ---------------------------------------------------------------
	// Format, out-of-frame window and error sources
	// ---------------------------------------------------------------
	assign fmt      = fmt_decode(cfg); // [RL7]
	assign fnum_cur = sf_start ? tfc_pkg::FBIT_FIRST : fnum + 5'h01;
	assign fer_in   = fbit_strobe & fbit_error
		& ~(fmt != tfc_pkg::TFC_ESF && cfg[tfc_pkg::CFG_JPN] && far_end_alarm
		&& fnum_cur == tfc_pkg::FBIT_ALARM); // [RL11]
	assign sev_in   = fer_in | (fmt == tfc_pkg::TFC_DM && sync_error); // [RL16]

	always_comb
	begin
		win_len = tfc_pkg::WIN_DM;
		thresh  = tfc_pkg::ERR_DM; // [RL3]
		if (fmt != tfc_pkg::TFC_DM)
		begin
			thresh = tfc_pkg::ERR_STD; // [RL2]
			case (cfg[tfc_pkg::CFG_RATIO +: 2])
				tfc_pkg::RATIO_2OF4: win_len = tfc_pkg::WIN_4;
				tfc_pkg::RATIO_2OF5: win_len = tfc_pkg::WIN_5;
				default:             win_len = tfc_pkg::WIN_6;
			endcase
		end
		case (fmt)
			tfc_pkg::TFC_ESF: bee_in = crc_bad; // [RL15]
			tfc_pkg::TFC_SLC: bee_in = fer_in & fbit_is_ft; // [RL15]
			tfc_pkg::TFC_DM:  bee_in = fer_in | sync_error; // [RL15]
			default:          bee_in = fer_in; // [RL15]
		endcase
	end

	tfc_oof_win #(
		.WMAX        (tfc_pkg::WIN_MAX)
	) u_oof (
		.core_clk    (core_clk),
		.reset       (reset),
		.hold        (hold || frm == tfc_pkg::TFC_SEARCH),
		.fbit_strobe (fbit_strobe),
		.fbit_error  (fer_in),
		.win_len     (win_len),
		.thresh      (thresh),
		.oof         (oof)
	);

	// ---------------------------------------------------------------
	// CRC-6 over the line, frame search and per-superframe state
	// ---------------------------------------------------------------
	assign crc_fb  = crc[5] ^ ((line_bit_is_fbit && !jpn_esf_mode) ? 1'b1 : line_bit); // [RL10]
	assign lock_ok = (fmt != tfc_pkg::TFC_ESF) ? 1'b1
		: (cfg[tfc_pkg::CFG_ALGO] ? crc_ok : cand_count == 3'h1); // [RL5] [RL6]

	always_comb
	begin
		next_crc     = crc;
		next_crc_ok  = crc_ok;
		next_crc_bad = 1'b0;
		if (line_bit_valid)
			next_crc = {crc[4:0], 1'b0} ^ (crc_fb ? tfc_pkg::CRC_POLY : tfc_pkg::CRC_SEED); // [RL6]
		if (crc_check)
		begin
			next_crc     = tfc_pkg::CRC_SEED;
			next_crc_ok  = crc == crc_rx; // [RL6]
			next_crc_bad = crc != crc_rx && frm == tfc_pkg::TFC_INFRAME;
		end
		next_frm       = frm;
		next_pos       = pos;
		next_had_align = had_align;
		evt            = '0;
		if (frm == tfc_pkg::TFC_SEARCH && cand_lock && lock_ok)
		begin
			next_frm       = tfc_pkg::TFC_INFRAME;
			next_pos       = cand_pos;
			next_had_align = 1'b1;
			evt[5]         = had_align && cand_pos != pos; // [RL13]
		end
		else if (frm == tfc_pkg::TFC_INFRAME && oof)
			next_frm = tfc_pkg::TFC_SEARCH;
		next_mimic = cand_count > 3'h1; // [RL17]
		evt[4] = fer_in; // [RL14]
		evt[3] = bee_in;
		evt[1] = next_mimic != mimic_present; // [RL17] [RL20]
		evt[0] = next_frm != frm; // [RL23]
		next_fnum      = fbit_strobe ? fnum_cur : fnum;
		next_sf_errs   = sf_start ? 2'h0 : sf_errs;
		if (sev_in && sf_errs != 2'h3)
			next_sf_errs = next_sf_errs + 2'h1;
		evt[2] = sev_in && next_sf_errs == 2'h2; // [RL16]
		next_fdl_valid = fbit_strobe && fmt == tfc_pkg::TFC_ESF
			&& cfg[tfc_pkg::CFG_FMS +: 2] == tfc_pkg::FMS_SF && fnum_cur[0]; // [RL8]
		next_fdl_bit   = next_fdl_valid ? fbit_value : fdl_bit;
		next_alarm     = far_end_alarm;
		if (fbit_strobe && fmt != tfc_pkg::TFC_ESF && cfg[tfc_pkg::CFG_JPN]
			&& fnum_cur == tfc_pkg::FBIT_ALARM)
			next_alarm = fbit_value; // [RL11]
		if (hold)
		begin
			next_frm   = tfc_pkg::TFC_SEARCH;
			next_alarm = 1'b0;
			next_mimic = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			crc           <= tfc_pkg::CRC_SEED;
			crc_ok        <= 1'b0;
			crc_bad       <= 1'b0;
			frm           <= tfc_pkg::TFC_SEARCH;
			pos           <= '0;
			had_align     <= 1'b0;
			fnum          <= 5'h00;
			sf_errs       <= 2'h0;
			fdl_bit       <= 1'b0;
			fdl_valid     <= 1'b0;
			far_end_alarm <= 1'b0;
			mimic_present <= 1'b0;
			inframe_state <= 1'b0;
			jpn_esf_mode  <= 1'b0;
			irq_out_n     <= 1'b1;
		end
		else
		begin
			crc           <= next_crc;
			crc_ok        <= next_crc_ok;
			crc_bad       <= next_crc_bad;
			frm           <= next_frm;
			pos           <= next_pos;
			had_align     <= next_had_align;
			fnum          <= next_fnum;
			sf_errs       <= next_sf_errs;
			fdl_bit       <= next_fdl_bit;
			fdl_valid     <= next_fdl_valid;
			far_end_alarm <= next_alarm;
			mimic_present <= next_mimic; // [RL21]
			inframe_state <= next_frm == tfc_pkg::TFC_INFRAME; // [RL21]
			jpn_esf_mode  <= next_cfg[tfc_pkg::CFG_JPN] && next_cfg[tfc_pkg::CFG_ESF]; // [RL10]
			irq_out_n     <= next_irq_n;
		end
	end

	// ---------------------------------------------------------------
	// Event flags and interrupt output
	// ---------------------------------------------------------------
	tfc_evt_flags #(
		.N        (tfc_pkg::NUM_EVT)
	) u_flags (
		.core_clk (core_clk),
		.reset    (reset),
		.hold     (hold),
		.set      (hold ? 6'h00 : evt),
		.clr      (clr_ist),
		.flags    (flags)
	);

	assign next_irq_n = ~|(flags & ien[5:0]); // [RL18] [RL24]

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	a_irq_gate: assert property (##1 irq_out_n == ~|($past(flags) & $past(ien[5:0]))) // [RL24]
		else $error("interrupt output does not follow enabled flags");
	a_hold_clears: assert property (hold |=> cfg == 8'h00 && ien == 8'h00 && flags == 6'h00) // [RL1]
		else $error("held reset did not clear registers");
	a_mimic_algo0: assert property (frm == tfc_pkg::TFC_SEARCH && fmt == tfc_pkg::TFC_ESF
		&& !cfg[tfc_pkg::CFG_ALGO] && cand_count > 3'h1 && !hold |=> !inframe_state) // [RL5]
		else $error("locked while mimics present");
	a_cofa_event: assert property (evt[5] && !hold |=> flags[5]) // [RL13]
		else $error("alignment change not flagged");
	a_fer_event: assert property (fer_in && !hold |=> flags[4]) // [RL14]
		else $error("framing error not flagged");
	a_fdl_odd: assert property (fdl_valid |-> $past(fnum_cur[0]) && $past(fmt) == tfc_pkg::TFC_ESF) // [RL8]
		else $error("data link bit taken from even frame");
	a_mimic_edge: assert property (!$past(hold) && $changed(mimic_present) |-> flags[1]) // [RL20]
		else $error("mimic change not flagged");
	a_inframe_state_edge: assert property (!$past(hold) && $changed(inframe_state) |-> flags[0]) // [RL23]
		else $error("in-frame change not flagged");
	c_lock: cover property (frm == tfc_pkg::TFC_SEARCH ##1 frm == tfc_pkg::TFC_INFRAME);
	c_oof: cover property (frm == tfc_pkg::TFC_INFRAME && oof);
	c_irq: cover property (!irq_out_n ##1 clr_ist);
endmodule // tfc_framer_ctl
`default_nettype wire

// ===== tfc_line_model.sv
// Line-side model: F-bit reports, candidate reports and idle serial bits
`timescale 1ns/1ps
`default_nettype none
module tfc_line_model (
	input  wire logic       core_clk,
	output var  logic       fbit_strobe,
	output var  logic       fbit_value,
	output var  logic       fbit_error,
	output var  logic       fbit_is_ft,
	output var  logic       sync_error,
	output var  logic       sf_start,
	output var  logic       line_bit,
	output var  logic       line_bit_valid,
	output var  logic       line_bit_is_fbit,
	output var  logic       crc_check,
	output var  logic [5:0] crc_rx,
	output var  logic       cand_lock,
	output var  logic [7:0] cand_pos,
	output var  logic [2:0] cand_count
);
	initial
	begin
		{fbit_strobe, fbit_value, fbit_error, fbit_is_ft, sync_error, sf_start} = 6'h0;
		{line_bit, line_bit_valid, line_bit_is_fbit, crc_check, cand_lock} = 5'h0;
		{crc_rx, cand_pos, cand_count} = 17'h0;
	end
	// Idle serial line toggles so no stale level is seen
	always @(posedge core_clk)
		line_bit <= ~line_bit;
	// One F-bit report, one cycle long
	task automatic fbit(input logic err, input logic first);
		@(posedge core_clk);
		fbit_strobe <= 1'b1;
		fbit_error <= err;
		sf_start <= first;
		@(posedge core_clk);
		{fbit_strobe, fbit_error, sf_start} <= 3'h0;
		fbit_value <= ~fbit_value;
	endtask
	// Alignment proposal with a candidate count
	task automatic lock(input logic [7:0] pos, input logic [2:0] n);
		@(posedge core_clk);
		cand_pos <= pos;
		cand_count <= n;
		cand_lock <= 1'b1;
		@(posedge core_clk);
		cand_lock <= 1'b0;
	endtask
	task automatic cnt(input logic [2:0] n);
		@(posedge core_clk);
		cand_count <= n;
	endtask
endmodule // tfc_line_model
`default_nettype wire

// ===== tfc_oof_win.sv
// Sliding window of framing bit errors that declares out of frame
`timescale 1ns/1ps
`default_nettype none
module tfc_oof_win #(
	parameter int WMAX = 12
) (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       hold,
	input  wire logic       fbit_strobe,
	input  wire logic       fbit_error,
	input  wire logic [3:0] win_len,
	input  wire logic [2:0] thresh,
	output var  logic       oof
);
	logic [WMAX-1:0] hist;
	logic [WMAX-1:0] next_hist;
	logic [WMAX-1:0] shifted;
	logic            next_oof;

	function automatic logic [3:0] count_win(input logic [WMAX-1:0] h, input logic [3:0] len);
		logic [3:0] c;
		c = 4'h0;
		for (int i = 0; i < WMAX; i++)
			if (i < int'(len) && h[i])
				c = c + 4'h1;
		return c;
	endfunction

	// ---------------------------------------------------------------
	// Error history and declaration
	// ---------------------------------------------------------------
	always_comb
	begin
		shifted   = {hist[WMAX-2:0], fbit_error};
		next_hist = hist;
		next_oof  = 1'b0;
		if (hold)
			next_hist = '0;
		else if (fbit_strobe)
		begin
			next_hist = shifted;
			if (count_win(shifted, win_len) >= {1'b0, thresh}) // [RL2] [RL3]
			begin
				next_oof  = 1'b1;
				next_hist = '0;
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			hist <= '0;
			oof  <= 1'b0;
		end
		else
		begin
			hist <= next_hist;
			oof  <= next_oof;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	a_oof_two_errs: assert property (!hold && fbit_strobe && fbit_error && hist[0]
		&& thresh == 3'h2 |=> oof) // [RL2]
		else $error("two adjacent errors did not declare out of frame");
	a_oof_needs_err: assert property (oof |-> $past(fbit_strobe) && $past(fbit_error)) // [RL3]
		else $error("out of frame without a framing error");
endmodule // tfc_oof_win
`default_nettype wire

// ===== tfc_pkg.sv
// Constants and types shared by the T1 framer control and event block
package tfc_pkg;
	// ---------------------------------------------------------------
	// Register indexes (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [7:0]  IDX_GCTL    = 8'h40;
	localparam logic [7:0]  IDX_CFG     = 8'h48;
	localparam logic [7:0]  IDX_IEN     = 8'h49;
	localparam logic [7:0]  IDX_IST     = 8'h4a;
	localparam int          AXI_AW      = 12;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int          GCTL_E1     = 0;
	localparam int          GCTL_UNF    = 1;
	localparam int          CFG_RATIO   = 6;
	localparam int          CFG_ALGO    = 5;
	localparam int          CFG_ESF     = 4;
	localparam int          CFG_FMS     = 2;
	localparam int          CFG_JPN     = 1;
	localparam logic [7:0]  CFG_MASK    = 8'hfe;
	localparam logic [7:0]  IEN_MASK    = 8'h7f;
	localparam logic [7:0]  REG_RST     = 8'h00;
	localparam int          NUM_EVT     = 6;
	localparam int          IST_EVT     = 2;
	// ---------------------------------------------------------------
	// Framing formats, ratios and timing counts
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {TFC_SF, TFC_ESF, TFC_DM, TFC_SLC} tfc_fmt_e;
	typedef enum logic {TFC_SEARCH, TFC_INFRAME} tfc_frm_e;
	localparam logic [1:0]  FMS_SF      = 2'h0;
	localparam logic [1:0]  FMS_SLC     = 2'h2;
	localparam logic [1:0]  RATIO_2OF4  = 2'h0;
	localparam logic [1:0]  RATIO_2OF5  = 2'h1;
	localparam logic [3:0]  WIN_4       = 4'h4;
	localparam logic [3:0]  WIN_5       = 4'h5;
	localparam logic [3:0]  WIN_6       = 4'h6;
	localparam logic [3:0]  WIN_DM      = 4'hc;
	localparam logic [2:0]  ERR_STD     = 3'h2;
	localparam logic [2:0]  ERR_DM      = 3'h4;
	localparam int          WIN_MAX     = 12;
	localparam logic [4:0]  FBIT_FIRST  = 5'h01;
	localparam logic [4:0]  FBIT_ALARM  = 5'h0c;
	localparam logic [5:0]  CRC_POLY    = 6'h03;
	localparam logic [5:0]  CRC_SEED    = 6'h00;
endpackage
